// File: logic/bsp_regs.vh
`ifndef BSP_REGS_VH
`define BSP_REGS_VH
// Register index of each set-point register; byte address is four times it
`define BSP_IDX_NORMAL      8'h3c
`define BSP_IDX_STANDBY     8'h3d
`define BSP_IDX_SLEEP       8'h3e
// Status register of our own: active code and reserved flag
`define BSP_IDX_STATUS      8'h41
// Field layout
`define BSP_CODE_MSB        5
`define BSP_RANGE_BIT       6
// Reset values
`define BSP_CODE_RESET      6'h00
// Strap wait count: range is taken once the counter reaches it
`define BSP_STRAP_SETTLE    2'h2
// Low range codes up to this value are reserved
`define BSP_LOW_RSVD_MAX    6'h08
// High range codes above this value are reserved
`define BSP_HIGH_MAX        6'h32
// Operating modes
`define BSP_MODE_NORMAL     2'h0
`define BSP_MODE_STANDBY    2'h1
`define BSP_MODE_SLEEP      2'h2
`endif

// File: logic/bsp_setpoint.v
// Functional notes
// - Range bit of the normal register is read-only; software writes leave it alone.
// - Range bit loads from the factory strap, never from software.
// - Range zero: code decodes to 0.625 V to 1.975 V in 25 mV steps.
// - Range one: code decodes to 0.800 V to 3.300 V in 50 mV steps.
// - Three independent writable six-bit codes: normal, standby, sleep.
// - Standby and sleep range bits copy the initial range bit.
// - Low range codes 0 to 8 are reserved; code 9 is 0.625 V.
// - High range code 0 is minimum, 50 is maximum, above is reserved.
`include "bsp_regs.vh"

module bsp_setpoint #(
    parameter CODE_W   = `BSP_CODE_MSB + 1,
    parameter IDX_W    = 8,
    parameter NUM_MODE = 3,
    parameter SETTLE_W = 2
) (
    input  wire              sys_clk,
    input  wire              rst_b,
    input  wire              hsel,
    input  wire [31:0]       haddr,
    input  wire [1:0]        htrans,
    input  wire              hwrite,
    input  wire [2:0]        hsize,
    input  wire [31:0]       hwdata,
    input  wire              hready,
    output reg  [31:0]       hrdata,
    output reg               hreadyout,
    output reg               hresp,
    input  wire              range_strap,
    input  wire [1:0]        op_mode,
    output reg  [CODE_W:0]   third_buck_setpoint,
    output reg               setpoint_reserved
);

    // Zero fill above the range bit of a set-point word and above the status flag
    localparam PAD_W  = 32 - CODE_W - 1;
    localparam STAT_W = 32 - CODE_W - 2;

    // Code of each mode, one slot per mode, gathered in one vector
    wire [NUM_MODE*CODE_W-1:0] code_flat;
    wire [CODE_W-1:0]          normal_code;
    wire [CODE_W-1:0]          standby_code;
    wire [CODE_W-1:0]          sleep_code;
    // Shared range bit and the strap path behind it
    reg                        range_sel;
    reg                        strap_meta;
    reg                        strap_sync;
    reg                        strap_taken;
    reg  [SETTLE_W-1:0]        strap_wait;
    wire [SETTLE_W:0]          next_strap_wait;
    // Operating mode level after the synchroniser
    reg  [1:0]                 mode_meta;
    reg  [1:0]                 mode_sync;
    // Address phase kept for the data phase of a write
    wire                       bus_take;
    wire [IDX_W-1:0]           addr_idx;
    reg                        wr_pend;
    reg  [IDX_W-1:0]           wr_idx;
    // Code of the mode now in force
    reg  [CODE_W-1:0]          active_code;
    reg                        next_rsvd;

    // Reserved-code check behind the output flag
    // Low range: small codes unused; high range: codes past the maximum
    function is_reserved;
        input              rng;
        input [CODE_W-1:0] code;
        begin
            if (rng)
                is_reserved = (code > `BSP_HIGH_MAX);
            else
                is_reserved = (code <= `BSP_LOW_RSVD_MAX);
        end
    endfunction

    // Register index that belongs to each mode slot
    // Slots follow mode order so that the mode code picks its slot
    function [IDX_W-1:0] slot_index;
        input integer slot;
        begin
            case (slot)
                0:       slot_index = `BSP_IDX_NORMAL;
                1:       slot_index = `BSP_IDX_STANDBY;
                default: slot_index = `BSP_IDX_SLEEP;
            endcase
        end
    endfunction

    // Register read view; set-point words read zero above bit 6, unmapped words read zero
    // Status word: flag in bit 7, active code below it
    function [31:0] read_word;
        input [IDX_W-1:0] idx;
        begin
            case (idx)
                `BSP_IDX_NORMAL:  read_word = {{PAD_W{1'b0}}, range_sel, normal_code};
                `BSP_IDX_STANDBY: read_word = {{PAD_W{1'b0}}, range_sel, standby_code};
                `BSP_IDX_SLEEP:   read_word = {{PAD_W{1'b0}}, range_sel, sleep_code};
                `BSP_IDX_STATUS:  read_word = {{STAT_W{1'b0}}, setpoint_reserved, third_buck_setpoint};
                default:          read_word = 32'h00000000;
            endcase
        end
    endfunction

    // Transfer taken at this edge and the word it names; upper address bits
    // are not decoded, so the register set repeats through the address space
    // Size of a transfer is not decoded: every register is one whole word
    assign bus_take = hready & hsel & htrans[1];
    assign addr_idx = haddr[IDX_W+1:2];

    // Strap wait counter widened by one bit so the carry is cut on purpose
    assign next_strap_wait = {1'b0, strap_wait} + {{SETTLE_W{1'b0}}, 1'b1};

    // Strap and mode come from outside: two flops before use
    // A mode change caught between its two bits lasts one cycle only
    // and always decodes to a legal mode, so no gray code is needed
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_meta <= 1'b0;
            strap_sync <= 1'b0;
            mode_meta  <= `BSP_MODE_NORMAL;
            mode_sync  <= `BSP_MODE_NORMAL;
        end else begin
            strap_meta <= range_strap;
            strap_sync <= strap_meta;
            mode_meta  <= op_mode;
            mode_sync  <= mode_meta;
        end
    end

    // Range latched once, after the strap has crossed both sync flops;
    // an earlier capture would take the reset value of the synchroniser.
    // No bus path reaches it, so all three modes stay on one scale
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            range_sel   <= 1'b0;
            strap_taken <= 1'b0;
            strap_wait  <= {SETTLE_W{1'b0}};
        end else if (!strap_taken) begin
            if (strap_wait == `BSP_STRAP_SETTLE) begin
                range_sel   <= strap_sync;
                strap_taken <= 1'b1;
            end else begin
                strap_wait  <= next_strap_wait[SETTLE_W-1:0];
            end
        end
    end

    // Bus slave: zero wait states and always OKAY, both held in flops so
    // that every output leaves a register
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_pend   <= 1'b0;
            wr_idx    <= {IDX_W{1'b0}};
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (hready) begin
                // Only the intent to write is noted; its data stands one cycle later
                wr_pend <= bus_take & hwrite;
                wr_idx  <= addr_idx;
                // Read data is fetched in the address phase and stands in the data phase
                if (bus_take & !hwrite) begin
                    hrdata <= read_word(addr_idx);
                end
            end
        end
    end

    // One writable code register per mode; bits above the code are dropped,
    // which keeps the range bit out of reach of software
    genvar g;
    generate
        for (g = 0; g < NUM_MODE; g = g + 1) begin : g_slot
            reg  [CODE_W-1:0] code_q;
            wire              slot_hit;
            // Write lands at the end of its data phase, when hwdata stands
            assign slot_hit = wr_pend & (wr_idx == slot_index(g));
            // Every slot resets to the same default code, BSP_CODE_RESET
            always @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    code_q <= `BSP_CODE_RESET;
                end else if (slot_hit) begin
                    code_q <= hwdata[CODE_W-1:0];
                end
            end
            assign code_flat[g*CODE_W +: CODE_W] = code_q;
        end
    endgenerate

    // Slots in mode order: normal, standby, sleep
    assign normal_code  = code_flat[0*CODE_W +: CODE_W];
    assign standby_code = code_flat[1*CODE_W +: CODE_W];
    assign sleep_code   = code_flat[2*CODE_W +: CODE_W];

    // Pick the code of the active mode; undefined mode falls back to normal
    // The code goes out even when reserved; the flag only reports it
    always @* begin
        case (mode_sync)
            `BSP_MODE_STANDBY: active_code = standby_code;
            `BSP_MODE_SLEEP:   active_code = sleep_code;
            default:           active_code = normal_code;
        endcase
        next_rsvd = is_reserved(range_sel, active_code);
    end

    // Shared range bit keeps all three modes on one scale
    // Code and flag share one register stage so they always change together
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            third_buck_setpoint <= {(CODE_W+1){1'b0}};
            setpoint_reserved   <= 1'b1;
        end else begin
            third_buck_setpoint <= {range_sel, active_code};
            setpoint_reserved   <= next_rsvd;
        end
    end

endmodule // bsp_setpoint

// File: tb/bsp_chk_asserts.sv
module bsp_chk (
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [1:0]  op_mode,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [6:0]  third_buck_setpoint,
    input wire logic        setpoint_reserved
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // Read request and short alias of the output code
    wire       rd = hsel && htrans[1] && !hwrite;
    wire [6:0] sp = third_buck_setpoint;
    property p_rdy; hreadyout; endproperty
    a_rdy: assert property (p_rdy) else $error("wait state");
    property p_ok; !hresp; endproperty
    a_ok: assert property (p_ok) else $error("error response");
    // Waits of 8 cycles skip the range capture after reset
    property p_rd; rd && haddr inside {32'hf0, 32'hf4, 32'hf8} && $past(rst_b, 8)
        |=> hrdata[31:6] == {25'h0, sp[6]}; endproperty
    a_rd: assert property (p_rd) else $error("set-point read");
    property p_unmap; rd && haddr < 32'hf0 |=> hrdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_range; $past(rst_b, 8) |-> $stable(sp[6]); endproperty
    a_range: assert property (p_range) else $error("range moved");
    property p_low; $past(rst_b, 8) && !sp[6] |-> setpoint_reserved == (sp[5:0] <= 6'h08); endproperty
    a_low: assert property (p_low) else $error("low flag");
    property p_high; $past(rst_b, 8) && sp[6] |-> setpoint_reserved == (sp[5:0] > 6'h32); endproperty
    a_high: assert property (p_high) else $error("high flag");
    property p_hold; ($stable(op_mode) && !(hsel && htrans[1]))[*6] ##0 $past(rst_b, 8) |=> $stable(sp); endproperty
    a_hold: assert property (p_hold) else $error("code moved");
    c_wr: cover property (hsel && htrans[1] && hwrite);
    c_rsvd: cover property ($rose(setpoint_reserved));
    c_mode: cover property ($changed(op_mode));
endmodule // bsp_chk

// File: tb/bsp_setpoint_test.sv
module bsp_setpoint_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, range_strap = 1'b1;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0]  htrans = 2'h0, op_mode = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic        hreadyout, hresp, setpoint_reserved;
    logic [6:0]  third_buck_setpoint;
    wire         hready = hreadyout;
    int          err_count = 0, n_checks = 0;
    bsp_setpoint i_bsp_setpoint (
        .sys_clk             (sys_clk),
        .rst_b               (rst_b),
        .hsel                (hsel),
        .haddr               (haddr),
        .htrans              (htrans),
        .hwrite              (hwrite),
        .hsize               (hsize),
        .hwdata              (hwdata),
        .hready              (hready),
        .hrdata              (hrdata),
        .hreadyout           (hreadyout),
        .hresp               (hresp),
        .range_strap         (range_strap),
        .op_mode             (op_mode),
        .third_buck_setpoint (third_buck_setpoint),
        .setpoint_reserved   (setpoint_reserved)
    );
    always #4 sys_clk = ~sys_clk;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One word transfer; the watchdog bounds both waits
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= a;
        do @(posedge sys_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic start(input logic s);
        rst_b <= 1'b0;
        range_strap <= s;
        repeat (10) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge sys_clk);
    endtask
    // Ones written to bits 7:6 must not reach the range
    task automatic t_regs(input logic [5:0] v[3]);
        bus(1'b0, 32'hf4, 32'h0);
        check(rd, {25'h0, range_strap, 6'h00});
        for (int i = 0; i < 3; i++) bus(1'b1, 32'hf0 + 4 * i, {24'h0, 2'h3, v[i]});
        bus(1'b1, 32'h104, 32'hff);
        for (int i = 0; i < 3; i++) begin
            bus(1'b0, 32'hf0 + 4 * i, 32'h0);
            check(rd, {25'h0, range_strap, v[i]});
        end
        bus(1'b0, 32'h10, 32'h0);
        check(rd, 32'h0);
        $display("regs done");
    endtask
    // Mode 3 counts as normal; flag follows range limits
    task automatic t_mode(input logic [5:0] v[3]);
        logic [5:0] c;
        logic [7:0] e;
        for (int m = 3; m >= 0; m--) begin
            c = v[m % 3];
            op_mode <= 2'(m);
            repeat (8) @(posedge sys_clk);
            e = {range_strap ? c > 6'h32 : c <= 6'h08, range_strap, c};
            check({setpoint_reserved, third_buck_setpoint}, e);
            bus(1'b0, 32'h104, 32'h0);
            check(rd, {24'h0, e});
        end
        $display("mode done");
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        start(1'b1);
        t_regs('{6'h32, 6'h33, 6'h18});
        t_mode('{6'h32, 6'h33, 6'h18});
        start(1'b0);
        t_regs('{6'h08, 6'h09, 6'h3f});
        t_mode('{6'h08, 6'h09, 6'h3f});
        finish_test;
    end
    initial begin
        #20000;
        err_count++;
        finish_test;
    end
endmodule // bsp_setpoint_test
bind bsp_setpoint bsp_chk i_bsp_chk (
    .sys_clk             (sys_clk),
    .rst_b               (rst_b),
    .hsel                (hsel),
    .haddr               (haddr),
    .htrans              (htrans),
    .hwrite              (hwrite),
    .op_mode             (op_mode),
    .hrdata              (hrdata),
    .hreadyout           (hreadyout),
    .hresp               (hresp),
    .third_buck_setpoint (third_buck_setpoint),
    .setpoint_reserved   (setpoint_reserved)
);
